//--- ccms_sequencer.sv
// module: capture mode sequencer with APB register file
//
// Added by the designer: the APB interface to the registers and the register offsets.
`timescale 1ns/1ns
`default_nettype none

// What this block does
// - freerun: frames follow each other, paced by the frame period setting
// - freerun: exposure of one frame overlaps transfer of the previous
// - frame period and exposure time are separate registers
// - freerun single frame: transfer next exposed frame, then stop
// - flash off in freerun single frame, allowed in freerun live
// - freerun live runs until host issues stop
// - trigger mode: sensor idles, exposure starts only on trigger
// - trigger from software command or input edge, per source select
// - software source single request: one exposure now, then transfer
// - software source live: repeated self-triggered exposures and transfers
// - hardware source single: arm for one edge, one frame, disarm
// - hardware source live: one frame per edge, re-arm after transfer
// - sync mode: freerun live, each trigger aborts and restarts capture
// - sequence: buffers used in order, wrapping, event per full pass
// - protected sequence buffers are skipped until released
// - trigger mode: exposure then transfer, never overlapped
// - trigger-complete event after a triggered frame transfer ends
module ccms_sequencer #(
  parameter int NBUF = ccms_pkg::NUM_BUF
) (
  input  wire logic                    clk_sys,
  input  wire logic                    sys_rst,
  input  wire ccms_pkg::ccms_apb_req_t apbReq,
  output var  ccms_pkg::ccms_apb_rsp_t apbRsp,
  input  wire logic                    trigIn,
  output var  ccms_pkg::ccms_cap_t     cap
);
  import ccms_pkg::*;

  if (NBUF < 2 || NBUF > (1 << BUF_W)) begin : g_nbuf_check
    $error("NBUF out of range");
  end

  // ==========================================================================
  // state
  typedef struct packed {
    logic [1:0]       src;
    logic             seqEn;
    logic [31:0]      period;
    logic [31:0]      expose;
    logic [31:0]      xfer;
    logic [BUF_W-1:0] actBuf;
    logic [NBUF-1:0]  inSeq;
    logic [NBUF-1:0]  prot;
    logic             running;
    logic             live;
    logic             snapPend;
    logic [31:0]      perCnt;
    logic [31:0]      expCnt;
    logic             expBusy;
    logic [31:0]      xfrCnt;
    logic             xfrBusy;
    logic             expDoneHold;
    ccms_trig_t       tst;
    logic             trigPrev;
    logic [BUF_W-1:0] seqPos;
    logic             tdoneSticky;
    logic             cycSticky;
    logic             frameDone;
    logic             trigDone;
    logic             cycleDone;
    logic [31:0]      rdata;
    logic             rdy;
  } ccms_state_t;

  ccms_state_t st_ff;
  ccms_state_t nxt_st;

  // next sequence buffer after pos, skipping unlisted and protected ones
  function automatic logic [BUF_W:0] nextBuf(
    input logic [BUF_W-1:0] pos,
    input logic [NBUF-1:0]  usable
  );
    logic [BUF_W:0] res;
    logic           found;
    logic [BUF_W-1:0] cand;
    res   = {1'b0, pos};
    found = 1'b0;
    for (int i = 1; i <= NBUF; i++) begin
      cand = BUF_W'((int'(pos) + i) % NBUF);
      if (!found && usable[cand]) begin
        found = 1'b1;
        res   = {((int'(pos) + i) >= NBUF), cand};
      end
    end
    return res;
  endfunction : nextBuf

  logic            wrEn;
  logic            rdEn;
  logic            trigEdge;
  logic            swTrig;
  logic            freerun;
  logic            startExp;
  logic            expEnd;
  logic            xfrEnd;
  logic [BUF_W:0]  nb;
  logic [NBUF-1:0] usable;

  assign wrEn     = apbReq.psel && apbReq.penable && apbReq.pwrite;
  assign rdEn     = apbReq.psel && !apbReq.penable && !apbReq.pwrite;
  assign trigEdge = trigIn && !st_ff.trigPrev;
  assign swTrig   = wrEn && apbReq.paddr == OFS_CMD &&
                    apbReq.pwdata[CMD_SWTRIG];
  assign freerun  = st_ff.src == CCMS_SRC_OFF || st_ff.src == CCMS_SRC_SYNC;
  assign expEnd   = st_ff.expBusy && st_ff.expCnt == 32'h0;
  assign xfrEnd   = st_ff.xfrBusy && st_ff.xfrCnt == 32'h0;
  assign usable   = st_ff.inSeq & ~st_ff.prot;
  assign nb       = nextBuf(st_ff.seqPos, usable);

  // ==========================================================================
  // next state
  always_comb begin
    nxt_st           = st_ff;
    nxt_st.trigPrev  = trigIn;
    nxt_st.frameDone = 1'b0;
    nxt_st.trigDone  = 1'b0;
    nxt_st.cycleDone = 1'b0;
    nxt_st.rdy       = apbReq.psel && !apbReq.penable;
    startExp         = 1'b0;
    // counters
    if (st_ff.expBusy && st_ff.expCnt != 32'h0) begin
      nxt_st.expCnt = st_ff.expCnt - 32'h1;
    end
    if (st_ff.xfrBusy && st_ff.xfrCnt != 32'h0) begin
      nxt_st.xfrCnt = st_ff.xfrCnt - 32'h1;
    end
    if (st_ff.perCnt != 32'h0) begin
      nxt_st.perCnt = st_ff.perCnt - 32'h1;
    end
    if (expEnd) begin
      nxt_st.expBusy     = 1'b0;
      nxt_st.expDoneHold = 1'b1;
    end
    // exposed frame moves to transfer once the link is free
    if ((expEnd || st_ff.expDoneHold) && !st_ff.xfrBusy) begin
      nxt_st.expDoneHold = 1'b0;
      nxt_st.xfrBusy     = st_ff.running;
      nxt_st.xfrCnt      = st_ff.xfer;
      if (st_ff.tst == CCMS_EXPOSE) begin
        nxt_st.tst = CCMS_XFER;
      end
    end
    if (xfrEnd) begin
      nxt_st.xfrBusy   = 1'b0;
      nxt_st.frameDone = 1'b1;
      if (st_ff.seqEn) begin
        nxt_st.seqPos    = nb[BUF_W-1:0];
        nxt_st.cycleDone = nb[BUF_W];
      end
      if (!st_ff.live) begin
        nxt_st.running = 1'b0;
      end
      if (st_ff.tst == CCMS_XFER) begin
        nxt_st.trigDone = 1'b1;
        if (st_ff.live && st_ff.running) begin
          startExp   = st_ff.src == CCMS_SRC_SW;
          nxt_st.tst = st_ff.src == CCMS_SRC_SW ? CCMS_EXPOSE
                                                 : CCMS_ARMED;
        end else begin
          nxt_st.tst = CCMS_IDLE;
        end
      end
    end
    // freerun: period-paced exposures, overlapping transfers
    if (freerun && st_ff.running && st_ff.perCnt == 32'h0 &&
        !st_ff.expBusy && (st_ff.live || st_ff.snapPend)) begin
      startExp        = 1'b1;
      nxt_st.snapPend = 1'b0;
    end
    // sync mode: edge aborts and restarts
    if (st_ff.src == CCMS_SRC_SYNC && st_ff.running && trigEdge) begin
      nxt_st.xfrBusy     = 1'b0;
      nxt_st.expDoneHold = 1'b0;
      startExp           = 1'b1;
    end
    // trigger mode: only armed state accepts a trigger
    if (st_ff.tst == CCMS_ARMED) begin
      if ((st_ff.src == CCMS_SRC_HW && trigEdge) ||
          (st_ff.src == CCMS_SRC_SW && swTrig)) begin
        nxt_st.tst = CCMS_EXPOSE;
        startExp   = 1'b1;
      end
    end
    if (startExp) begin
      nxt_st.expBusy = 1'b1;
      nxt_st.expCnt  = st_ff.expose;
      nxt_st.perCnt  = st_ff.period;
    end
    // commands and register writes
    if (wrEn) begin
      if (apbReq.paddr == OFS_CTRL) begin
        nxt_st.src   = apbReq.pwdata[CTRL_SRC_LSB +: 2];
        nxt_st.seqEn = apbReq.pwdata[CTRL_SEQ_BIT];
      end else if (apbReq.paddr == OFS_PERIOD) begin
        nxt_st.period = apbReq.pwdata;
      end else if (apbReq.paddr == OFS_EXPOSE) begin
        nxt_st.expose = apbReq.pwdata;
      end else if (apbReq.paddr == OFS_XFER) begin
        nxt_st.xfer = apbReq.pwdata;
      end else if (apbReq.paddr == OFS_ACTBUF) begin
        nxt_st.actBuf = apbReq.pwdata[BUF_W-1:0];
      end else if (apbReq.paddr == OFS_PROTECT) begin
        nxt_st.prot = apbReq.pwdata[NBUF-1:0];
      end else if (apbReq.paddr == OFS_STATUS) begin
        nxt_st.tdoneSticky = st_ff.tdoneSticky &
                             ~apbReq.pwdata[ST_TDONE_BIT];
        nxt_st.cycSticky   = st_ff.cycSticky & ~apbReq.pwdata[ST_CYC_BIT];
      end else if (apbReq.paddr == OFS_CMD) begin
        if (apbReq.pwdata[CMD_APPEND]) begin
          nxt_st.inSeq[apbReq.pwdata[8 +: BUF_W]] = 1'b1;
        end
        if (apbReq.pwdata[CMD_CLEAR]) begin
          nxt_st.inSeq = '0;
        end
        if (apbReq.pwdata[CMD_SINGLE] || apbReq.pwdata[CMD_CONT]) begin
          nxt_st.running  = 1'b1;
          nxt_st.live     = apbReq.pwdata[CMD_CONT];
          nxt_st.snapPend = 1'b1;
          // start on a listed, unprotected buffer
          if (st_ff.seqEn && !usable[st_ff.seqPos]) begin
            nxt_st.seqPos = nb[BUF_W-1:0];
          end
          if (!freerun) begin
            nxt_st.tst = st_ff.src == CCMS_SRC_SW ? CCMS_EXPOSE
                                                  : CCMS_ARMED;
            if (st_ff.src == CCMS_SRC_SW) begin
              nxt_st.expBusy = 1'b1;
              nxt_st.expCnt  = st_ff.expose;
            end
          end
        end
        if (apbReq.pwdata[CMD_STOP]) begin
          nxt_st.running  = 1'b0;
          nxt_st.live     = 1'b0;
          nxt_st.snapPend = 1'b0;
          nxt_st.tst      = CCMS_IDLE;
        end
      end
    end
    // events win over a clear in the same cycle
    if (nxt_st.trigDone) begin
      nxt_st.tdoneSticky = 1'b1;
    end
    if (nxt_st.cycleDone) begin
      nxt_st.cycSticky = 1'b1;
    end
    // read data
    nxt_st.rdata = 32'h0;
    if (rdEn) begin
      if (apbReq.paddr == OFS_CTRL) begin
        nxt_st.rdata = {29'h0, st_ff.seqEn, st_ff.src};
      end else if (apbReq.paddr == OFS_PERIOD) begin
        nxt_st.rdata = st_ff.period;
      end else if (apbReq.paddr == OFS_EXPOSE) begin
        nxt_st.rdata = st_ff.expose;
      end else if (apbReq.paddr == OFS_XFER) begin
        nxt_st.rdata = st_ff.xfer;
      end else if (apbReq.paddr == OFS_SEQ) begin
        nxt_st.rdata = {{(32-NBUF){1'b0}}, st_ff.inSeq};
      end else if (apbReq.paddr == OFS_PROTECT) begin
        nxt_st.rdata = {{(32-NBUF){1'b0}}, st_ff.prot};
      end else if (apbReq.paddr == OFS_ACTBUF) begin
        nxt_st.rdata = {{(32-BUF_W){1'b0}}, st_ff.actBuf};
      end else if (apbReq.paddr == OFS_STATUS) begin
        nxt_st.rdata = {13'h0, st_ff.seqPos, 10'h0, st_ff.cycSticky,
                        st_ff.tdoneSticky, st_ff.running,
                        st_ff.tst == CCMS_ARMED, st_ff.xfrBusy,
                        st_ff.expBusy};
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      st_ff        <= '0;
      st_ff.period <= RST_PERIOD;
      st_ff.expose <= RST_EXPOSE;
      st_ff.xfer   <= RST_XFER;
      st_ff.tst    <= CCMS_IDLE;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ==========================================================================
  // outputs
  assign apbRsp.pready  = st_ff.rdy;
  assign apbRsp.pslverr = 1'b0;
  assign apbRsp.prdata  = st_ff.rdata;
  assign cap.frameValid = st_ff.xfrBusy;
  assign cap.exposing   = st_ff.expBusy;
  assign cap.flashEn    = st_ff.expBusy && (st_ff.live || !freerun);
  assign cap.bufIdx     = st_ff.seqEn ? st_ff.seqPos : st_ff.actBuf;
  assign cap.frameDone  = st_ff.frameDone;
  assign cap.trigDone   = st_ff.trigDone;
  assign cap.cycleDone  = st_ff.cycleDone;

  // ==========================================================================
  // checks
  AST_NO_OVERLAP_TRIG: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (st_ff.src inside {CCMS_SRC_SW, CCMS_SRC_HW} && st_ff.tst != CCMS_IDLE)
    |-> !(st_ff.expBusy && st_ff.xfrBusy)) else $error("overlap");
  AST_TDONE_AFTER_XFER: assert property (@(posedge clk_sys)
    disable iff (sys_rst) cap.trigDone |-> $past(st_ff.xfrBusy))
    else $error("trig done without transfer");
  AST_IDLE_NO_EXPOSE: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (st_ff.tst == CCMS_ARMED && !trigEdge && !swTrig && !wrEn)
    |=> !$rose(st_ff.expBusy)) else $error("exposure untriggered");
  AST_HW_EDGE_STARTS: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (st_ff.tst == CCMS_ARMED && st_ff.src == CCMS_SRC_HW && trigEdge && !wrEn)
    |=> st_ff.expBusy && st_ff.tst == CCMS_EXPOSE)
    else $error("edge lost");
  AST_FLASH_SNAP: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (freerun && !st_ff.live) |-> !cap.flashEn)
    else $error("flash in snap");
  AST_PROT_SKIP: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (st_ff.seqEn && xfrEnd && |usable) |=> usable[st_ff.seqPos] ||
    !$past(usable[nb[BUF_W-1:0]])) else $error("protected used");
  AST_EXPOSE_LEN: assert property (@(posedge clk_sys) disable iff (sys_rst)
    $rose(st_ff.expBusy) |-> st_ff.expCnt == st_ff.expose)
    else $error("exposure length");
  AST_SNAP_STOPS: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (xfrEnd && !st_ff.live && !wrEn) |=> !st_ff.running)
    else $error("snap kept running");

endmodule : ccms_sequencer

`default_nettype wire

//--- ccms_pkg.sv
// package: constants, types and register map of the capture sequencer
package ccms_pkg;

  // ==========================================================================
  // register offsets
  localparam logic [11:0] OFS_CTRL    = 12'h000;
  localparam logic [11:0] OFS_CMD     = 12'h004;
  localparam logic [11:0] OFS_PERIOD  = 12'h008;
  localparam logic [11:0] OFS_EXPOSE  = 12'h00c;
  localparam logic [11:0] OFS_XFER    = 12'h010;
  localparam logic [11:0] OFS_SEQ     = 12'h014;
  localparam logic [11:0] OFS_PROTECT = 12'h018;
  localparam logic [11:0] OFS_STATUS  = 12'h01c;
  localparam logic [11:0] OFS_ACTBUF  = 12'h020;

  // ==========================================================================
  // field positions
  localparam int CTRL_SRC_LSB  = 0;   // trigger source, 2 bits
  localparam int CTRL_SEQ_BIT  = 2;   // sequence enable
  localparam int CMD_SINGLE    = 0;
  localparam int CMD_CONT      = 1;
  localparam int CMD_STOP      = 2;
  localparam int CMD_SWTRIG    = 3;
  localparam int CMD_APPEND    = 4;
  localparam int CMD_CLEAR     = 5;
  localparam int ST_EXP_BIT    = 0;
  localparam int ST_XFR_BIT    = 1;
  localparam int ST_ARM_BIT    = 2;
  localparam int ST_RUN_BIT    = 3;
  localparam int ST_TDONE_BIT  = 4;
  localparam int ST_CYC_BIT    = 5;

  // ==========================================================================
  // reset values and counts
  localparam logic [31:0] RST_PERIOD = 32'h0000_0064;
  localparam logic [31:0] RST_EXPOSE = 32'h0000_0032;
  localparam logic [31:0] RST_XFER   = 32'h0000_0028;
  localparam int          NUM_BUF    = 8;
  localparam int          BUF_W      = 3;

  typedef enum logic [1:0] {
    CCMS_SRC_OFF, CCMS_SRC_SW, CCMS_SRC_HW, CCMS_SRC_SYNC
  } ccms_src_t;

  typedef enum {
    CCMS_IDLE, CCMS_ARMED, CCMS_EXPOSE, CCMS_XFER
  } ccms_trig_t;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } ccms_apb_req_t;

  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } ccms_apb_rsp_t;

  typedef struct packed {
    logic             frameValid;   // transfer in progress
    logic             exposing;
    logic             flashEn;
    logic [BUF_W-1:0] bufIdx;
    logic             frameDone;    // pulse at end of a transfer
    logic             trigDone;     // pulse, trigger-complete event
    logic             cycleDone;    // pulse, sequence pass complete
  } ccms_cap_t;

endpackage : ccms_pkg

//--- ccms_host_model.sv
// host driver model: apb master issuing register accesses
`timescale 1ns/1ns
`default_nettype none
module ccms_host_model (
  input  wire logic                    clk_sys,
  input  wire ccms_pkg::ccms_apb_rsp_t apbRsp,
  output var  ccms_pkg::ccms_apb_req_t apbReq
);
  import ccms_pkg::*;
  initial apbReq = '0;
  // ==========================================================================
  // one transfer: setup, access until pready, release
  task automatic xfer(input logic wr, input logic [11:0] a,
                      input logic [31:0] d, output logic [31:0] q);
    @(posedge clk_sys);
    apbReq <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
    @(posedge clk_sys);
    apbReq.penable <= 1'b1;
    do @(posedge clk_sys); while (apbRsp.pready !== 1'b1);
    q = apbRsp.prdata;
    apbReq <= '0;
  endtask : xfer
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    xfer(1'b1, a, d, q);
  endtask : wr
  task automatic rd(input logic [11:0] a, output logic [31:0] q);
    xfer(1'b0, a, 32'h0, q);
  endtask : rd
  // ==========================================================================
  // mode setup: source written first, then period, exposure and transfer times
  task automatic cfg(input logic [1:0] src, input logic sq);
    wr(OFS_CTRL, {29'h0, sq, src});
    wr(OFS_PERIOD, 32'h1e);
    wr(OFS_EXPOSE, 32'h09);
    wr(OFS_XFER, 32'h0c);
  endtask : cfg
  task automatic cmd(input int b);
    wr(OFS_CMD, 32'h1 << b);
  endtask : cmd
endmodule : ccms_host_model
`default_nettype wire

//--- camera_capture_mode_sequencer_bench.sv
// testbench: capture mode scenarios against the sequencer
`timescale 1ns/1ns
`default_nettype none
module camera_capture_mode_sequencer_bench;
  import ccms_pkg::*;
  logic                 clk_sys = 1'b0;
  logic                 sys_rst = 1'b1;
  logic                 trigIn  = 1'b0;
  ccms_apb_req_t        apbReq;
  ccms_apb_rsp_t        apbRsp;
  ccms_cap_t            cap;
  logic [31:0]          q;
  int                   fail_count = 0;
  int                   n_checks = 0;
  int                   nFr, nTd, nCy, nFl, nOv, nEx, nB2;
  int                   nEr = 0;
  always #5 clk_sys = ~clk_sys;
  ccms_sequencer DUT (.clk_sys(clk_sys), .sys_rst(sys_rst), .apbReq(apbReq),
    .apbRsp(apbRsp), .trigIn(trigIn), .cap(cap));
  ccms_host_model host (.clk_sys(clk_sys), .apbRsp(apbRsp), .apbReq(apbReq));
  // ==========================================================================
  // event counters
  always @(posedge clk_sys) begin
    nFr += (cap.frameDone === 1'b1);
    nTd += (cap.trigDone === 1'b1);
    nCy += (cap.cycleDone === 1'b1);
    nFl += (cap.flashEn === 1'b1);
    nOv += (cap.exposing === 1'b1 && cap.frameValid === 1'b1);
    nEx += (cap.exposing === 1'b1);
    nB2 += (cap.frameValid === 1'b1 && cap.bufIdx === 3'h2);
    nEr += (apbRsp.pslverr !== 1'b0);
  end
  task automatic clr;
    @(negedge clk_sys);
    {nFr, nTd, nCy, nFl, nOv, nEx, nB2} = '0;
  endtask : clr
  task automatic chk(input string nm, input int lo, input int hi,
                     input int got);
    n_checks++;
    if (got < lo || got > hi) begin
      fail_count++;
      $display("MISMATCH %s expected %0d..%0d seen %0d", nm, lo, hi, got);
    end
  endtask : chk
  task automatic run(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : run
  task automatic pulse;
    @(posedge clk_sys);
    trigIn <= 1'b1;
    run(3);
    trigIn <= 1'b0;
  endtask : pulse
  // ==========================================================================
  // scenarios
  task automatic t_regs;
    host.rd(OFS_PERIOD, q);
    chk("period", 1, 1, int'(q === RST_PERIOD));
    host.wr(OFS_PERIOD, 32'h1e);
    host.rd(OFS_EXPOSE, q);
    chk("expose", 1, 1, int'(q === RST_EXPOSE));
    host.rd(OFS_XFER, q);
    chk("xfer", 1, 1, int'(q === RST_XFER));
    host.rd(12'h0f0, q);
    chk("unmapped", 1, 1, int'(q === 32'h0));
    $display("test regs done");
  endtask : t_regs
  task automatic t_free;
    host.cfg(2'd0, 1'b0);
    host.wr(OFS_ACTBUF, 32'h5);
    host.wr(OFS_XFER, 32'h1c);
    clr();
    host.cmd(CMD_CONT);
    run(300);
    chk("bufidx", 1, 1, int'(cap.bufIdx === 3'h5));
    host.cmd(CMD_STOP);
    run(60);
    chk("live frames", 9, 11, nFr);
    chk("overlap", 1, 999, nOv);
    chk("live flash", 1, 999, nFl);
    clr();
    run(100);
    chk("after stop", 0, 0, nFr);
    host.cmd(CMD_SINGLE);
    run(150);
    chk("snap frames", 1, 1, nFr);
    chk("snap flash", 0, 0, nFl);
    $display("test freerun done");
  endtask : t_free
  task automatic t_sw;
    host.cfg(2'd1, 1'b0);
    clr();
    host.cmd(CMD_SWTRIG);
    run(20);
    chk("sw unarmed", 0, 0, nEx);
    host.cmd(CMD_SINGLE);
    run(3);
    chk("sw start", 1, 999, nEx);
    run(60);
    chk("sw frames", 1, 1, nFr);
    chk("sw tdone", 1, 1, nTd);
    host.rd(OFS_STATUS, q);
    chk("tdone sticky", 1, 1, int'(q[ST_TDONE_BIT] === 1'b1));
    host.wr(OFS_STATUS, 32'h1 << ST_TDONE_BIT);
    host.rd(OFS_STATUS, q);
    chk("tdone clear", 1, 1, int'(q[ST_TDONE_BIT] === 1'b0));
    host.cmd(CMD_CONT);
    run(200);
    host.cmd(CMD_STOP);
    run(60);
    chk("sw live", 5, 999, nFr);
    chk("sw overlap", 0, 0, nOv);
    $display("test sw trigger done");
  endtask : t_sw
  task automatic t_hw;
    host.cfg(2'd2, 1'b0);
    clr();
    pulse();
    run(50);
    chk("unarmed", 0, 0, nEx + nFr);
    host.cmd(CMD_SINGLE);
    pulse();
    run(50);
    pulse();
    run(50);
    chk("hw single", 1, 1, nFr);
    clr();
    host.cmd(CMD_CONT);
    pulse();
    pulse();
    run(50);
    pulse();
    run(50);
    pulse();
    run(50);
    host.cmd(CMD_STOP);
    chk("hw live", 3, 3, nFr);
    chk("hw tdone", 3, 3, nTd);
    chk("hw overlap", 0, 0, nOv);
    $display("test hw trigger done");
  endtask : t_hw
  task automatic t_sync;
    host.cfg(2'd3, 1'b0);
    host.cmd(CMD_CONT);
    run(100);
    clr();
    repeat (10) begin
      pulse();
      run(11);
    end
    chk("sync abort", 0, 0, nFr);
    chk("sync expose", 1, 999, nEx);
    run(100);
    host.cmd(CMD_STOP);
    chk("sync resume", 1, 999, nFr);
    $display("test sync done");
  endtask : t_sync
  task automatic t_seq;
    host.cfg(2'd0, 1'b1);
    host.cmd(CMD_CLEAR);
    for (int i = 1; i < 4; i++) host.wr(OFS_CMD, 32'h10 | (i << 8));
    host.wr(OFS_PROTECT, 32'h4);
    clr();
    host.cmd(CMD_CONT);
    run(400);
    host.cmd(CMD_STOP);
    run(60);
    chk("protected", 0, 0, nB2);
    chk("pass event", 3, 999, nCy);
    host.rd(OFS_STATUS, q);
    chk("cycle sticky", 1, 1, int'(q[ST_CYC_BIT] === 1'b1));
    host.rd(OFS_SEQ, q);
    chk("seq list", 1, 1, int'(q === 32'h0000_000e));
    host.wr(OFS_PROTECT, 32'h0);
    clr();
    host.cmd(CMD_CONT);
    run(200);
    host.cmd(CMD_STOP);
    chk("released", 1, 999, nB2);
    chk("slverr", 0, 0, nEr);
    $display("test sequence done");
  endtask : t_seq
  // ==========================================================================
  // verdict and main sequence
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : report_and_stop
  initial begin
    run(4);
    sys_rst <= 1'b0;
    t_regs();
    t_free();
    t_sw();
    t_hw();
    t_sync();
    t_seq();
    report_and_stop();
  end
  initial begin
    #400000;
    fail_count++;
    report_and_stop();
  end
endmodule : camera_capture_mode_sequencer_bench
`default_nettype wire
